// ==== bench/dod_decoder_asserts.sv ====
`timescale 1ns/1ps
module dod_decoder_asserts (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic word_valid,
  input wire logic [15:0] word,
  input wire logic word_ready,
  input wire logic instr_valid,
  input wire dod_pkg::dod_instr_t instr,
  input wire logic unrecognised
);
  logic pend;
  logic next_pend;
  logic [15:0] last_word;
  logic [15:0] next_last;
  logic take;
  logic fresh;
  logic long_first;
  ////////////////////////////////////////
  // Mirror of the pending constant, so a constant is never read as opcode
  assign take = ce && word_valid;
  assign fresh = take && !pend;
  assign long_first = word[15:8] == 8'hae || word[15:4] == 12'hbfa
    || word[15:4] == 12'hbfd || word == 16'hbe83;
  always_comb begin
    next_pend = pend;
    next_last = word;
    if (rst) begin
      next_pend = 1'b0;
    end else if (take) begin
      next_pend = !pend && long_first;
    end
  end
  always_ff @(posedge clk_sys) begin
    pend <= next_pend;
    last_word <= next_last;
  end
  ////////////////////////////////////////
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_long;
    fresh && long_first;
  endsequence
  sequence s_const;
    take && pend;
  endsequence
  pop_acc_a: assert property (
    fresh && word == 16'hbe32 |=> instr_valid
    && instr.op == dod_pkg::DOD_OP_POP_ACC && instr.cycles == 3'h1)
    else $error("pop to accumulator misdecoded");
  pop_mem_a: assert property (
    fresh && word[15:8] == 8'h8a |=> instr.op == dod_pkg::DOD_OP_POP_TO_MEMORY
    && instr.direct_indirect_addr_field == last_word[7:0])
    else $error("pop to memory misdecoded");
  ret_cond_a: assert property (
    fresh && word[15:10] == 6'h3b && word != 16'hef00 |=> instr.op ==
    dod_pkg::DOD_OP_RETURN_CONDITIONAL && instr.cycles == 3'h4
    && instr.cycles_alt == 3'h2 && instr.test_pin_cond == last_word[9:8])
    else $error("conditional return misdecoded");
  store_acc_a: assert property (
    fresh && word[15:12] == 4'h9 |=> instr.op == (last_word[11] ?
    dod_pkg::DOD_OP_STORE_ACC_HIGH : dod_pkg::DOD_OP_STORE_ACC_LOW)
    && instr.shift_amount == {1'b0, last_word[10:8]})
    else $error("accumulator store misdecoded");
  table_ops_a: assert property (
    fresh && word[15:9] == 7'h53 |=> instr_valid && instr.cycles == 3'h3)
    else $error("table access cycle count wrong");
  hold_quiet_a: assert property (
    s_long |=> !instr_valid && !unrecognised)
    else $error("output issued before constant word");
  const_pair_a: assert property (
    s_const |=> instr_valid && instr.const_word == last_word
    && instr.words == 2'h2 && instr.cycles == 3'h2)
    else $error("two-word instruction not issued whole");
  freeze_hold_a: assert property (
    !ce |=> $stable(instr) && $stable(instr_valid) && $stable(unrecognised))
    else $error("outputs moved while clock enable low");
  unknown_word_a: assert property (
    fresh && word == 16'hffff |=> unrecognised && !instr_valid
    && instr.op == dod_pkg::DOD_OP_NONE)
    else $error("unlisted word not flagged");
endmodule
bind dod_decoder dod_decoder_asserts chk (.clk_sys, .rst, .ce, .word_valid,
  .word, .word_ready, .instr_valid, .instr, .unrecognised);

// ==== bench/dod_fetch_model.sv ====
`timescale 1ns/1ps
// Fetch stage stand-in; call just after a rising edge
module dod_fetch_model (
  input wire logic clk_sys,
  output logic word_valid,
  output logic [15:0] word
);
  initial begin
    word_valid = 1'b0;
    word = 16'h0000;
  end
  // Released bus shows the inverse, so a stale word can never match
  task automatic send(input logic [15:0] w, input bit hold);
    word_valid = 1'b1;
    word = w;
    @(posedge clk_sys);
    #1;
    if (!hold) begin
      word_valid = 1'b0;
      word = ~w;
    end
  endtask
endmodule

// ==== bench/dsp_opcode_decoder_pop_to_zero_low_load_high_round_bench.sv ====
`timescale 1ns/1ps
module dsp_opcode_decoder_pop_to_zero_low_load_high_round_bench;
  typedef struct packed {
    logic [15:0] w;
    dod_pkg::dod_op_t op;
    logic [1:0] fld;
    logic [2:0] cyc;
  } dod_case_t;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic word_valid;
  logic [15:0] word;
  logic word_ready;
  logic instr_valid;
  logic unrecognised;
  dod_pkg::dod_instr_t instr;
  int miscompares = 0;
  int checks = 0;
  always #2.5 clk_sys = ~clk_sys;
  dod_fetch_model fetch (.clk_sys, .word_valid, .word);
  dod_decoder dut (.clk_sys, .rst, .ce, .word_valid, .word, .word_ready,
    .instr_valid, .instr, .unrecognised);
  ////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] e,
    input logic [15:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic one_ok(input dod_pkg::dod_op_t op, input logic [2:0] cyc,
    input logic [1:0] wd);
    chk("op", 16'(op), 16'(instr.op));
    chk("valid", 16'h1, 16'(instr_valid));
    chk("unrec", 16'h0, 16'(unrecognised));
    chk("words", 16'(wd), 16'(instr.words));
    chk("cycles", 16'(cyc), 16'(instr.cycles));
  endtask
  ////////////////////////////////////////
  // Back to back, so a stale record from the word before shows up
  task automatic t_single;
    dod_case_t t[19] = '{
      '{16'hbe32, dod_pkg::DOD_OP_POP_ACC, 2'h0, 3'h1},
      '{16'h8a12, dod_pkg::DOD_OP_POP_TO_MEMORY, 2'h1, 3'h1},
      '{16'h7634, dod_pkg::DOD_OP_PUSH_FROM_MEMORY, 2'h1, 3'h1},
      '{16'hbe3c, dod_pkg::DOD_OP_PUSH_ACC, 2'h0, 3'h1},
      '{16'h0b56, dod_pkg::DOD_OP_REPEAT_NEXT_MEM, 2'h1, 3'h1},
      '{16'hbbff, dod_pkg::DOD_OP_REPEAT_NEXT_IMM, 2'h2, 3'h1},
      '{16'h7c80, dod_pkg::DOD_OP_AUX_REG_DECREMENT_IMM,
        2'h2, 3'h1},
      '{16'hbe45, dod_pkg::DOD_OP_STATUS_BIT_SET, 2'h0, 3'h1},
      '{16'hbe05, dod_pkg::DOD_OP_PRODUCT_MINUS_ACC, 2'h0, 3'h1},
      '{16'h8e9a, dod_pkg::DOD_OP_STATUS_STORE_ZERO, 2'h1, 3'h1},
      '{16'h8f00, dod_pkg::DOD_OP_STATUS_STORE_ONE, 2'h1, 3'h1},
      '{16'h3fc3, dod_pkg::DOD_OP_MINUS_SHIFT, 2'h3, 3'h1},
      '{16'hba01, dod_pkg::DOD_OP_MINUS_SHORT_IMM, 2'h2, 3'h1},
      '{16'h6477, dod_pkg::DOD_OP_MINUS_WITH_BORROW, 2'h1, 3'h1},
      '{16'h66e1, dod_pkg::DOD_OP_MINUS_LOW_NO_SIGN_EXT,
        2'h1, 3'h1},
      '{16'h672c, dod_pkg::DOD_OP_MINUS_SHIFT_BY_T, 2'h1, 3'h1},
      '{16'ha655, dod_pkg::DOD_OP_TABLE_READ_OP, 2'h1, 3'h3},
      '{16'ha7aa, dod_pkg::DOD_OP_TABLE_WRITE_OP, 2'h1, 3'h3},
      '{16'h6899, dod_pkg::DOD_OP_ZERO_LOW_LOAD_HIGH_ROUND,
        2'h1, 3'h1}
    };
    foreach (t[i]) begin
      fetch.send(t[i].w, 1'b1);
      one_ok(t[i].op, t[i].cyc, 2'h1);
      if (t[i].fld[0]) begin
        chk("addr", {8'h00, t[i].w[7:0]},
          16'(instr.direct_indirect_addr_field));
      end
      if (t[i].fld == 2'h2) begin
        chk("imm", {8'h00, t[i].w[7:0]}, 16'(instr.immediate_bits));
      end
      if (t[i].fld == 2'h3) begin
        chk("shift", 16'(t[i].w[11:8]), 16'(instr.shift_amount));
      end
      if (t[i].w == 16'hbe45) begin
        chk("setbit", 16'(dod_pkg::DOD_SET_BLOCK_PROGRAM),
          16'(instr.set_bit));
      end
    end
  endtask
  task automatic t_store;
    for (int i = 0; i < 16; i++) begin
      fetch.send({4'h9, 4'(i), 8'h3c}, 1'b1);
      one_ok(i[3] ? dod_pkg::DOD_OP_STORE_ACC_HIGH :
        dod_pkg::DOD_OP_STORE_ACC_LOW, 3'h1, 2'h1);
      chk("shift", 16'(i[2:0]), 16'(instr.shift_amount));
    end
  endtask
  task automatic t_ret;
    for (int i = 0; i < 4; i++) begin
      fetch.send({6'h3b, 2'(i), 8'h6a}, 1'b1);
      one_ok(dod_pkg::DOD_OP_RETURN_CONDITIONAL, 3'h4, 2'h1);
      chk("alt", 16'h2, 16'(instr.cycles_alt));
      chk("testpin", 16'(i), 16'(instr.test_pin_cond));
      chk("flags", 16'ha, 16'(instr.cond_flags_field));
    end
  endtask
  // Constants that look like opcodes must still be taken as data
  task automatic t_long;
    logic [15:0] f[3] = '{16'hae05, 16'hbfa7, 16'hbe83};
    logic [15:0] k[3] = '{16'hffff, 16'hbe32, 16'h0000};
    dod_pkg::dod_op_t o[3] = '{dod_pkg::DOD_OP_STORE_LONG_IMM,
      dod_pkg::DOD_OP_MINUS_LONG_IMM_SHIFT,
      dod_pkg::DOD_OP_XOR_LONG_IMM_HIGH};
    for (int i = 0; i < 3; i++) begin
      fetch.send(f[i], 1'b0);
      ce = 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
      chk("early", 16'h0, 16'({instr_valid, unrecognised}));
      ce = 1'b1;
      fetch.send(k[i], i != 2);
      one_ok(o[i], 3'h2, 2'h2);
      chk("const", k[i], instr.const_word);
      chk("field", i == 1 ? 16'(f[i][3:0]) : 16'(f[i][7:0]),
        i == 1 ? 16'(instr.shift_amount) :
        16'(instr.direct_indirect_addr_field));
    end
  endtask
  task automatic t_unknown;
    fetch.send(16'hffff, 1'b1);
    chk("unrec", 16'h2, 16'({unrecognised, instr_valid}));
    fetch.send(16'hfe00, 1'b1);
    chk("unrec", 16'h2, 16'({unrecognised, instr_valid}));
    chk("op", 16'(dod_pkg::DOD_OP_NONE), 16'(instr.op));
  endtask
  // Reset in mid-pair drops the pending first word
  task automatic t_reset;
    fetch.send(16'hae05, 1'b0);
    rst = 1'b1;
    @(posedge clk_sys);
    #1;
    rst = 1'b0;
    chk("rstout", 16'h0,
      16'({instr != '0, instr_valid, unrecognised}));
    chk("ready", 16'h1, 16'(word_ready));
    fetch.send(16'hbe32, 1'b0);
    one_ok(dod_pkg::DOD_OP_POP_ACC, 3'h1, 2'h1);
  endtask
  ////////////////////////////////////////
  task automatic summarize;
    if (miscompares == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    t_single;
    t_store;
    t_ret;
    t_long;
    t_unknown;
    t_reset;
    summarize;
  end
  initial begin
    repeat (3000) @(posedge clk_sys);
    miscompares++;
    summarize;
  end
endmodule

// ==== design/dod_const_hold.sv ====
`timescale 1ns/1ps
// Holds a pending first word until its constant word arrives
module dod_const_hold (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic load,
  input wire logic complete,
  input wire dod_pkg::dod_instr_t first_in,
  output dod_pkg::dod_instr_t first_held,
  output logic pending
);

  dod_pkg::dod_instr_t held;
  dod_pkg::dod_instr_t next_held;
  logic busy;
  logic next_busy;

  always_comb begin
    next_held = held;
    next_busy = busy;
    if (complete) begin
      next_busy = 1'b0;
    end
    if (load) begin
      next_held = first_in; // [RULE23]
      next_busy = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      held <= dod_pkg::DOD_INSTR_RESET;
      busy <= 1'b0;
    end else if (ce) begin
      held <= next_held;
      busy <= next_busy;
    end
  end

  assign first_held = held;
  assign pending = busy;

endmodule

// ==== design/dod_decoder.sv ====
`timescale 1ns/1ps
// Functional notes
// RULE1 - 0xbe32 decodes as pop stack top to low accumulator, 1/1
// RULE2 - Upper byte 0x8a is pop_to_memory with address byte, 1/1
// RULE3 - Upper byte 0x76 is push_from_memory with address byte, 1/1
// RULE4 - 0xbe3c decodes as push low accumulator, 1/1
// RULE5 - Upper byte 0xec-0xef is return_conditional, 4 cycles taken, 2 not; code decodes 0xef00 as plain return, 4 cycles
// RULE6 - Upper byte 0x0b is repeat_next with count from memory, 1 cycle
// RULE7 - Upper byte 0xbb is repeat_next with immediate count, 1/1
// RULE8 - Top nibble 9 stores accumulator, bit 11 high/low, 3-bit shift
// RULE9 - Upper byte 0x7c subtracts immediate from current aux register
// RULE10 - 0xbe45 sets block-as-program-memory status bit, 1 cycle
// RULE11 - 0xbe05 subtracts product register from accumulator, 1/1
// RULE12 - 0x8e stores status zero, 0x8f stores status one, 1 cycle
// RULE13 - Upper byte 0xae is store_long_imm with next-word constant, 2/2
// RULE14 - 0xbfa plus shift nibble subtracts shifted next-word constant, 2/2
// RULE15 - Top nibble 3 subtracts shifted memory operand, 1 cycle
// RULE16 - Upper byte 0xba subtracts short immediate from accumulator, 1/1
// RULE17 - Upper byte 0x64 subtracts memory with borrow, 1 cycle
// RULE18 - Upper byte 0x66 subtracts without sign extension, 1 cycle
// RULE19 - Upper byte 0x67 subtracts shifted by multiplicand register
// RULE20 - 0xa6 is table read, 0xa7 table write, each 1/3
// RULE21 - 0xbe83 plus constant word is XOR shifted left 16
// RULE22 - Upper byte 0x68 zeroes low, loads high with rounding, 1/1
// RULE23 - Two-word instructions held until constant arrives, issued as one
// RULE24 - Unlisted patterns raise unrecognised indication, no operation

////////////////////////////////////////////////////////////////////////////
module dod_decoder (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic word_valid,
  input wire logic [15:0] word,
  output logic word_ready,
  output logic instr_valid,
  output dod_pkg::dod_instr_t instr,
  output logic unrecognised
);

  ////////////////////////////////////////////////////////////////////////////
  // First word classification

  dod_pkg::dod_instr_t cls;
  dod_pkg::dod_instr_t held;
  logic pending;
  logic load_first;
  logic take_const;

  dod_word_class u_class (
    .word(word),
    .info(cls)
  );

  // A word arriving while pending is always the constant, never decoded
  assign take_const = pending && word_valid; // [RULE23]
  assign load_first = !pending && word_valid && cls.has_const; // [RULE23]

  dod_const_hold u_hold (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .load(load_first),
    .complete(take_const),
    .first_in(cls),
    .first_held(held),
    .pending(pending)
  );

  // Decoder never stalls fetch: one word is accepted per enabled cycle
  assign word_ready = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Output registers

  dod_pkg::dod_instr_t next_instr;
  logic next_valid;
  logic next_unrec;

  always_comb begin
    next_instr = instr;
    next_valid = 1'b0;
    next_unrec = 1'b0;
    if (take_const) begin
      next_instr = held;
      next_instr.const_word = word; // [RULE13] [RULE14] [RULE21]
      next_valid = 1'b1; // [RULE23]
    end else if (word_valid && !cls.has_const) begin
      next_instr = cls;
      next_valid = !cls.unknown;
      next_unrec = cls.unknown; // [RULE24]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      instr <= dod_pkg::DOD_INSTR_RESET;
      instr_valid <= 1'b0;
      unrecognised <= 1'b0;
    end else if (ce) begin
      instr <= next_instr;
      instr_valid <= next_valid;
      unrecognised <= next_unrec;
    end
  end

endmodule

// ==== design/dod_pkg.sv ====
package dod_pkg;

  // Operation codes reported by the decoder
  typedef enum logic [5:0] {
    DOD_OP_NONE,
    DOD_OP_POP_ACC,
    DOD_OP_POP_TO_MEMORY,
    DOD_OP_PUSH_FROM_MEMORY,
    DOD_OP_PUSH_ACC,
    DOD_OP_RETURN,
    DOD_OP_RETURN_CONDITIONAL,
    DOD_OP_ROTATE_LEFT,
    DOD_OP_ROTATE_RIGHT,
    DOD_OP_REPEAT_NEXT_MEM,
    DOD_OP_REPEAT_NEXT_IMM,
    DOD_OP_STORE_ACC_HIGH,
    DOD_OP_STORE_ACC_LOW,
    DOD_OP_STORE_AUX,
    DOD_OP_AUX_REG_DECREMENT_IMM,
    DOD_OP_STATUS_BIT_SET,
    DOD_OP_SHIFT_LEFT,
    DOD_OP_SHIFT_RIGHT,
    DOD_OP_PRODUCT_MINUS_ACC,
    DOD_OP_STORE_P_HIGH,
    DOD_OP_STORE_P_LOW,
    DOD_OP_SET_P_SHIFT,
    DOD_OP_SQUARE_ADD,
    DOD_OP_SQUARE_SUB,
    DOD_OP_STATUS_STORE_ZERO,
    DOD_OP_STATUS_STORE_ONE,
    DOD_OP_STORE_LONG_IMM,
    DOD_OP_MINUS_LONG_IMM_SHIFT,
    DOD_OP_MINUS_SHIFT,
    DOD_OP_MINUS_HIGH,
    DOD_OP_MINUS_SHORT_IMM,
    DOD_OP_MINUS_WITH_BORROW,
    DOD_OP_MINUS_CONDITIONAL,
    DOD_OP_MINUS_LOW_NO_SIGN_EXT,
    DOD_OP_MINUS_SHIFT_BY_T,
    DOD_OP_TABLE_READ_OP,
    DOD_OP_TABLE_WRITE_OP,
    DOD_OP_SOFT_TRAP,
    DOD_OP_XOR_MEM,
    DOD_OP_XOR_LONG_IMM_SHIFT,
    DOD_OP_XOR_LONG_IMM_HIGH,
    DOD_OP_ZERO_LOW_LOAD_HIGH_ROUND
  } dod_op_t;

  // Status bit chosen by a status_bit_set word
  typedef enum logic [2:0] {
    DOD_SET_NONE,
    DOD_SET_CARRY,
    DOD_SET_BLOCK_PROGRAM,
    DOD_SET_INT_DISABLE,
    DOD_SET_OVERFLOW_MODE,
    DOD_SET_TEST_CONTROL,
    DOD_SET_EXT_FLAG,
    DOD_SET_SIGN_EXT_MODE
  } dod_status_bit_t;

  // Decoded instruction handed to execute
  typedef struct packed {
    dod_op_t op;
    dod_status_bit_t set_bit;
    logic [7:0] direct_indirect_addr_field;
    logic [7:0] immediate_bits;
    logic [3:0] shift_amount;
    logic [1:0] test_pin_cond;
    logic [3:0] cond_flags_field;
    logic [3:0] cond_flags_mask;
    logic [2:0] aux_sel;
    logic has_const;
    logic [15:0] const_word;
    logic [1:0] words;
    logic [2:0] cycles;
    logic [2:0] cycles_alt;
    logic unknown;
  } dod_instr_t;

  // Fixed patterns and prefixes
  localparam logic [7:0] DOD_PFX_MISC = 8'hbe;
  localparam logic [7:0] DOD_PFX_LONG = 8'hbf;
  localparam logic [15:0] DOD_W_POP_ACC = 16'hbe32;
  localparam logic [15:0] DOD_W_PUSH_ACC = 16'hbe3c;
  localparam logic [15:0] DOD_W_RETURN = 16'hef00;
  localparam logic [15:0] DOD_W_BLOCK_PROG = 16'hbe45;
  localparam logic [15:0] DOD_W_PROD_MINUS = 16'hbe05;
  localparam logic [15:0] DOD_W_XOR_HIGH = 16'hbe83;

  // Word and cycle counts
  localparam logic [1:0] DOD_WORDS_ONE = 2'h1;
  localparam logic [1:0] DOD_WORDS_TWO = 2'h2;
  localparam logic [2:0] DOD_CYC_ONE = 3'h1;
  localparam logic [2:0] DOD_CYC_TWO = 3'h2;
  localparam logic [2:0] DOD_CYC_THREE = 3'h3;
  localparam logic [2:0] DOD_CYC_FOUR = 3'h4;

  // Reset value of the output record
  localparam dod_instr_t DOD_INSTR_RESET = '0;

endpackage

// ==== design/dod_word_class.sv ====
`timescale 1ns/1ps
// Classifies one first word; pure combinational table
module dod_word_class (
  input wire logic [15:0] word,
  output dod_pkg::dod_instr_t info
);

  function automatic dod_pkg::dod_status_bit_t status_bit_of(
    input logic [3:0] n);
    unique case (n)
      4'hf: status_bit_of = dod_pkg::DOD_SET_CARRY;
      4'h5: status_bit_of = dod_pkg::DOD_SET_BLOCK_PROGRAM;
      4'h1: status_bit_of = dod_pkg::DOD_SET_INT_DISABLE;
      4'h3: status_bit_of = dod_pkg::DOD_SET_OVERFLOW_MODE;
      4'hb: status_bit_of = dod_pkg::DOD_SET_TEST_CONTROL;
      4'hd: status_bit_of = dod_pkg::DOD_SET_EXT_FLAG;
      4'h7: status_bit_of = dod_pkg::DOD_SET_SIGN_EXT_MODE;
      default: status_bit_of = dod_pkg::DOD_SET_NONE;
    endcase
  endfunction

  always_comb begin
    info = dod_pkg::DOD_INSTR_RESET;
    info.direct_indirect_addr_field = word[7:0];
    info.immediate_bits = word[7:0];
    info.words = dod_pkg::DOD_WORDS_ONE;
    info.cycles = dod_pkg::DOD_CYC_ONE;
    info.cycles_alt = dod_pkg::DOD_CYC_ONE;
    info.op = dod_pkg::DOD_OP_NONE;
    if (word == dod_pkg::DOD_W_POP_ACC) begin
      info.op = dod_pkg::DOD_OP_POP_ACC; // [RULE1]
    end else if (word == dod_pkg::DOD_W_PUSH_ACC) begin
      info.op = dod_pkg::DOD_OP_PUSH_ACC; // [RULE4]
    end else if (word == dod_pkg::DOD_W_PROD_MINUS) begin
      info.op = dod_pkg::DOD_OP_PRODUCT_MINUS_ACC; // [RULE11]
    end else if (word == dod_pkg::DOD_W_XOR_HIGH) begin
      info.op = dod_pkg::DOD_OP_XOR_LONG_IMM_HIGH; // [RULE21]
      info.has_const = 1'b1;
      info.words = dod_pkg::DOD_WORDS_TWO;
      info.cycles = dod_pkg::DOD_CYC_TWO;
      info.cycles_alt = dod_pkg::DOD_CYC_TWO;
    end else if (word == dod_pkg::DOD_W_RETURN) begin
      info.op = dod_pkg::DOD_OP_RETURN;
      info.cycles = dod_pkg::DOD_CYC_FOUR;
      info.cycles_alt = dod_pkg::DOD_CYC_FOUR;
    end else if (word[15:8] == dod_pkg::DOD_PFX_MISC) begin
      unique case (word[7:0])
        8'h0c: info.op = dod_pkg::DOD_OP_ROTATE_LEFT;
        8'h0d: info.op = dod_pkg::DOD_OP_ROTATE_RIGHT;
        8'h09: info.op = dod_pkg::DOD_OP_SHIFT_LEFT;
        8'h0a: info.op = dod_pkg::DOD_OP_SHIFT_RIGHT;
        8'h51: begin
          info.op = dod_pkg::DOD_OP_SOFT_TRAP;
          info.cycles = dod_pkg::DOD_CYC_FOUR;
          info.cycles_alt = dod_pkg::DOD_CYC_FOUR;
        end
        default: begin
          // Block program is one of the status set codes
          if (word[7:4] == 4'h4 && status_bit_of(word[3:0]) !=
              dod_pkg::DOD_SET_NONE) begin
            info.op = dod_pkg::DOD_OP_STATUS_BIT_SET; // [RULE10]
            info.set_bit = status_bit_of(word[3:0]);
          end else begin
            info.unknown = 1'b1; // [RULE24]
          end
        end
      endcase
    end else if (word[15:8] == dod_pkg::DOD_PFX_LONG) begin
      info.shift_amount = word[3:0];
      info.has_const = 1'b1;
      info.words = dod_pkg::DOD_WORDS_TWO;
      info.cycles = dod_pkg::DOD_CYC_TWO;
      info.cycles_alt = dod_pkg::DOD_CYC_TWO;
      unique case (word[7:4])
        4'ha: info.op = dod_pkg::DOD_OP_MINUS_LONG_IMM_SHIFT; // [RULE14]
        4'hd: info.op = dod_pkg::DOD_OP_XOR_LONG_IMM_SHIFT;
        default: begin
          // Set P shift mode is one word with address byte
          info.op = dod_pkg::DOD_OP_SET_P_SHIFT;
          info.has_const = 1'b0;
          info.shift_amount = 4'h0;
          info.words = dod_pkg::DOD_WORDS_ONE;
          info.cycles = dod_pkg::DOD_CYC_ONE;
          info.cycles_alt = dod_pkg::DOD_CYC_ONE;
        end
      endcase
    end else if (word[15:10] == 6'h3b) begin
      info.op = dod_pkg::DOD_OP_RETURN_CONDITIONAL; // [RULE5]
      info.test_pin_cond = word[9:8];
      info.cond_flags_field = word[3:0];
      info.cond_flags_mask = word[7:4];
      info.cycles = dod_pkg::DOD_CYC_FOUR;
      info.cycles_alt = dod_pkg::DOD_CYC_TWO;
    end else if (word[15:12] == 4'h9) begin
      info.shift_amount = {1'b0, word[10:8]}; // [RULE8]
      info.op = word[11] ? dod_pkg::DOD_OP_STORE_ACC_HIGH
                         : dod_pkg::DOD_OP_STORE_ACC_LOW;
    end else if (word[15:12] == 4'h3) begin
      info.op = dod_pkg::DOD_OP_MINUS_SHIFT; // [RULE15]
      info.shift_amount = word[11:8];
    end else if (word[15:11] == 5'h10) begin
      info.op = dod_pkg::DOD_OP_STORE_AUX;
      info.aux_sel = word[10:8];
    end else begin
      unique case (word[15:8])
        8'h8a: info.op = dod_pkg::DOD_OP_POP_TO_MEMORY; // [RULE2]
        8'h76: info.op = dod_pkg::DOD_OP_PUSH_FROM_MEMORY; // [RULE3]
        8'h0b: info.op = dod_pkg::DOD_OP_REPEAT_NEXT_MEM; // [RULE6]
        8'hbb: info.op = dod_pkg::DOD_OP_REPEAT_NEXT_IMM; // [RULE7]
        8'h7c: info.op = dod_pkg::DOD_OP_AUX_REG_DECREMENT_IMM; // [RULE9]
        8'h8e: info.op = dod_pkg::DOD_OP_STATUS_STORE_ZERO; // [RULE12]
        8'h8f: info.op = dod_pkg::DOD_OP_STATUS_STORE_ONE; // [RULE12]
        8'h8d: info.op = dod_pkg::DOD_OP_STORE_P_HIGH;
        8'h8c: info.op = dod_pkg::DOD_OP_STORE_P_LOW;
        8'h52: info.op = dod_pkg::DOD_OP_SQUARE_ADD;
        8'h53: info.op = dod_pkg::DOD_OP_SQUARE_SUB;
        8'hae: begin
          info.op = dod_pkg::DOD_OP_STORE_LONG_IMM; // [RULE13]
          info.has_const = 1'b1;
          info.words = dod_pkg::DOD_WORDS_TWO;
          info.cycles = dod_pkg::DOD_CYC_TWO;
          info.cycles_alt = dod_pkg::DOD_CYC_TWO;
        end
        8'h65: info.op = dod_pkg::DOD_OP_MINUS_HIGH;
        8'hba: info.op = dod_pkg::DOD_OP_MINUS_SHORT_IMM; // [RULE16]
        8'h64: info.op = dod_pkg::DOD_OP_MINUS_WITH_BORROW; // [RULE17]
        8'h0a: info.op = dod_pkg::DOD_OP_MINUS_CONDITIONAL;
        8'h66: info.op = dod_pkg::DOD_OP_MINUS_LOW_NO_SIGN_EXT; // [RULE18]
        8'h67: info.op = dod_pkg::DOD_OP_MINUS_SHIFT_BY_T; // [RULE19]
        8'ha6, 8'ha7: begin
          info.op = word[8] ? dod_pkg::DOD_OP_TABLE_WRITE_OP
                            : dod_pkg::DOD_OP_TABLE_READ_OP; // [RULE20]
          info.cycles = dod_pkg::DOD_CYC_THREE;
          info.cycles_alt = dod_pkg::DOD_CYC_THREE;
        end
        8'h6c: info.op = dod_pkg::DOD_OP_XOR_MEM;
        8'h68: info.op = dod_pkg::DOD_OP_ZERO_LOW_LOAD_HIGH_ROUND; // [RULE22]
        default: info.unknown = 1'b1; // [RULE24]
      endcase
    end
    // Unrecognised words never carry an operation
    if (info.unknown) begin
      info.op = dod_pkg::DOD_OP_NONE; // [RULE24]
    end
  end

endmodule
